// *** hdl/smspi_consts.vh ***
// Constants and register map of the serial module SPI core.
`ifndef SMSPI_CONSTS_VH
`define SMSPI_CONSTS_VH
`define SMSPI_ADDR_MODE 12'h000
`define SMSPI_ADDR_FMT 12'h004
`define SMSPI_ADDR_DATA 12'h008
`define SMSPI_MODE_RST 8'hE0
`define SMSPI_FMT_RST 8'h00
`define SMSPI_MODE_SEL_RST 3'h7
`define SMSPI_LIM_DIV4 6'h01
`define SMSPI_LIM_DIV16 6'h07
`define SMSPI_LIM_DIV64 6'h1F
`define SMSPI_LAST_HALF 4'hF
`define SMSPI_MODE_DIV4 3'h0
`define SMSPI_MODE_DIV16 3'h1
`define SMSPI_MODE_DIV64 3'h2
`define SMSPI_MODE_SUB 3'h3
`define SMSPI_MODE_TMR 3'h4
`define SMSPI_MODE_SLAVE 3'h5
`define SMSPI_MODE_I2C 3'h6
`define SMSPI_MODE_OFF 3'h7
`define SMSPI_MODE_HI 7
`define SMSPI_MODE_LO 5
`define SMSPI_BIT_EN 1
`define SMSPI_BIT_ICF 0
`define SMSPI_BIT_POL 5
`define SMSPI_BIT_EDGE 4
`define SMSPI_BIT_MSB 3
`define SMSPI_BIT_SELECT_PIN_ENABLE 2
`define SMSPI_BIT_WRITE_COLLISION_FLAG 1
`define SMSPI_BIT_TRF 0
`endif

// *** hdl/smspi_tick.v ***
// Serial clock tick generator: one enable pulse per half serial period.
`timescale 1ns/1ps
module smspi_tick #(
   parameter CW = 6
) (
   input wire pclk,
   input wire presetn,
   input wire run,
   input wire [2:0] mode,
   input wire sub_tick,
   input wire tmr_tick,
   output reg tick
);
`include "smspi_consts.vh"
   reg [CW-1:0] cnt_r;
   reg [CW-1:0] lim;
   // A full serial period is two ticks, so the count limit is half the divisor less one.
   always @* begin
      case (mode)
         `SMSPI_MODE_DIV4: lim = `SMSPI_LIM_DIV4;
         `SMSPI_MODE_DIV16: lim = `SMSPI_LIM_DIV16;
         default: lim = `SMSPI_LIM_DIV64;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= {CW{1'b0}};
         tick <= 1'b0;
      end else if (!run) begin
         cnt_r <= {CW{1'b0}};
         tick <= 1'b0;
      end else if (mode == `SMSPI_MODE_SUB) begin
         tick <= sub_tick;
      end else if (mode == `SMSPI_MODE_TMR) begin
         // Each match flips the clock level, giving half the match rate.
         tick <= tmr_tick;
      end else if (cnt_r == lim) begin
         cnt_r <= {CW{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// *** hdl/smspi_shift.v ***
// Eight-bit shift engine with selectable bit order.
`timescale 1ns/1ps
module smspi_shift (
   input wire pclk,
   input wire presetn,
   input wire load,
   input wire [7:0] load_data,
   input wire sample,
   input wire shift,
   input wire msb_first,
   input wire sdi,
   output reg [7:0] data,
   output wire out_bit
);
   reg in_bit_r;
   // MSB first sends bit 7 and fills bit 0; LSB first is the mirror.
   assign out_bit = msb_first ? data[7] : data[0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data <= 8'h00;
         in_bit_r <= 1'b0;
      end else if (load) begin
         data <= load_data;
      end else begin
         if (sample)
            in_bit_r <= sdi;
         if (shift) begin
            if (msb_first)
               data <= {data[6:0], sample ? sdi : in_bit_r};
            else
               data <= {sample ? sdi : in_bit_r, data[7:1]};
         end
      end
   end
endmodule

// *** hdl/smspi_core.v ***
// Serial module SPI core: APB registers, master clocking and slave engine.
`timescale 1ns/1ps
module smspi_core (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire sub_tick,
   input wire tmr_tick,
   input wire sck_in,
   input wire sdi,
   input wire ss_in_n,
   output reg sck_out,
   output reg sck_oe,
   output reg sdo,
   output reg sdo_oe,
   output reg slave_select_n,
   output reg ss_oe
);
`include "smspi_consts.vh"
   reg [2:0] mode_r;
   reg [1:0] deb_r;
   reg en_r;
   reg icf_r;
   reg [1:0] fmt_hi_r;
   reg pol_r;
   reg edge_r;
   reg msb_r;
   reg select_pin_enable_r;
   reg write_collision_flag_r;
   reg trf_r;
   reg busy_r;
   reg [3:0] half_r;
   reg sck_lvl_r;
   reg sck_q_r;
   reg ss_q_r;
   reg fin_r;
   reg wr_load;
   wire [7:0] sh_data;
   wire sh_out;
   wire tick;
   wire master = mode_r <= `SMSPI_MODE_TMR;
   wire slave = mode_r == `SMSPI_MODE_SLAVE;
   wire spi_on = en_r && (master || slave);
   wire acc = psel && penable;
   // A write lands only at the edge that sees ready high, so it lands once.
   wire wr = acc && pready && pwrite;
   wire wr_mode = wr && paddr == `SMSPI_ADDR_MODE;
   wire wr_fmt = wr && paddr == `SMSPI_ADDR_FMT;
   wire wr_data = wr && paddr == `SMSPI_ADDR_DATA;
   wire mapped = paddr == `SMSPI_ADDR_MODE || paddr == `SMSPI_ADDR_FMT ||
                 paddr == `SMSPI_ADDR_DATA;
   // Clock idle level: pol 0 idles high, pol 1 idles low.
   wire idle_lvl = ~pol_r;
   // Whatever the idle level, edge bit set means capture on the leading edge.
   wire lead_cap = edge_r;
   wire m_tick = master && busy_r && tick;
   // In master mode the first half period captures when leading edge is
   // the capture edge; otherwise the second half does.
   wire m_lead = m_tick && !half_r[0];
   wire m_trail = m_tick && half_r[0];
   wire m_sample = lead_cap ? m_lead : m_trail;
   // With trailing capture the first bit already stands before the first
   // edge, so that edge must not shift; the last shift follows the frame.
   wire m_shift = lead_cap ? m_trail : m_lead && half_r != 4'h0;
   // Slave edges come from the external clock sampled on pclk.
   wire s_act = slave && spi_on && !(select_pin_enable_r && ss_in_n);
   wire s_rise = s_act && sck_in && !sck_q_r;
   wire s_fall = s_act && !sck_in && sck_q_r;
   wire s_cap = edge_r ? s_fall : s_rise;
   wire s_cap_x = pol_r ? (edge_r ? s_rise : s_fall) : s_cap;
   wire s_lead = s_rise | s_fall;
   wire s_shift = s_lead && !s_cap_x && (lead_cap || half_r != 4'h0);
   wire do_sample = m_sample | s_cap_x;
   wire do_shift = m_shift | s_shift | (fin_r && !lead_cap);
   // Master ends after 16 half periods; slave ends on its sixteenth edge.
   wire m_done = m_tick && half_r == `SMSPI_LAST_HALF;
   wire s_last = s_lead && half_r == `SMSPI_LAST_HALF;
   wire s_abort = slave && spi_on && select_pin_enable_r && ss_in_n && !ss_q_r &&
                  busy_r;
   wire done = m_done | s_last;
   wire collide = wr_data && busy_r;

   smspi_tick #(
      .CW(6)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .run(master && busy_r),
      .mode(mode_r),
      .sub_tick(sub_tick),
      .tmr_tick(tmr_tick),
      .tick(tick)
   );

   always @* begin
      wr_load = wr_data && !busy_r;
   end

   smspi_shift u_shift (
      .pclk(pclk),
      .presetn(presetn),
      .load(wr_load),
      .load_data(pwdata[7:0]),
      .sample(do_sample),
      .shift(do_shift),
      .msb_first(msb_r),
      .sdi(sdi),
      .data(sh_data),
      .out_bit(sh_out)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= `SMSPI_MODE_SEL_RST;
         deb_r <= 2'h0;
         en_r <= 1'b0;
         icf_r <= 1'b0;
         fmt_hi_r <= 2'h0;
         pol_r <= 1'b0;
         edge_r <= 1'b0;
         msb_r <= 1'b0;
         select_pin_enable_r <= 1'b0;
         write_collision_flag_r <= 1'b0;
         trf_r <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_r <= pwdata[`SMSPI_MODE_HI:`SMSPI_MODE_LO];
            deb_r <= pwdata[3:2];
            en_r <= pwdata[`SMSPI_BIT_EN];
         end
         // The incomplete flag also sets the done flag, but a software
         // write of one to it does not.
         if (s_abort)
            icf_r <= 1'b1;
         else if (wr_mode)
            icf_r <= pwdata[`SMSPI_BIT_ICF];
         if (wr_fmt) begin
            fmt_hi_r <= pwdata[7:6];
            pol_r <= pwdata[`SMSPI_BIT_POL];
            edge_r <= pwdata[`SMSPI_BIT_EDGE];
            msb_r <= pwdata[`SMSPI_BIT_MSB];
            select_pin_enable_r <= pwdata[`SMSPI_BIT_SELECT_PIN_ENABLE];
         end
         if (collide)
            write_collision_flag_r <= 1'b1;
         else if (wr_fmt)
            write_collision_flag_r <= pwdata[`SMSPI_BIT_WRITE_COLLISION_FLAG];
         if (done || s_abort)
            trf_r <= 1'b1;
         else if (wr_fmt)
            trf_r <= pwdata[`SMSPI_BIT_TRF];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
         half_r <= 4'h0;
         sck_q_r <= 1'b1;
         ss_q_r <= 1'b1;
         fin_r <= 1'b0;
      end else begin
         fin_r <= done;
         sck_q_r <= sck_in;
         ss_q_r <= ss_in_n;
         if (!spi_on || s_abort) begin
            busy_r <= 1'b0;
            half_r <= 4'h0;
         end else if (master) begin
            if (wr_load)
               busy_r <= 1'b1;
            else if (m_done)
               busy_r <= 1'b0;
            if (wr_load)
               half_r <= 4'h0;
            else if (m_tick)
               half_r <= half_r + 4'h1;
         end else begin
            // A slave is busy from its first clock edge to the last one.
            if (s_last)
               busy_r <= 1'b0;
            else if (s_lead)
               busy_r <= 1'b1;
            if (s_last)
               half_r <= 4'h0;
            else if (s_lead)
               half_r <= half_r + 4'h1;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_lvl_r <= 1'b1;
         sck_out <= 1'b1;
         sck_oe <= 1'b0;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
         slave_select_n <= 1'b1;
         ss_oe <= 1'b0;
      end else begin
         if (!(master && busy_r))
            sck_lvl_r <= idle_lvl;
         else if (m_tick)
            sck_lvl_r <= ~sck_lvl_r;
         sck_out <= sck_lvl_r;
         sck_oe <= spi_on && master;
         sdo <= sh_out;
         sdo_oe <= spi_on && (master || s_act);
         // A single select output; it stays low until one cycle after the
         // last clock edge, so the far side still sees its final edge
         // selected. It floats whenever its enable bit is clear.
         slave_select_n <= !(master && (busy_r || fin_r));
         ss_oe <= spi_on && master && select_pin_enable_r;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // One wait state: the answer is registered, ready on the next edge.
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata <= 32'h0000_0000;
         if (psel && !pwrite) begin
            case (paddr)
               `SMSPI_ADDR_MODE:
                  prdata[7:0] <= {mode_r, 1'b0, deb_r, en_r, icf_r};
               `SMSPI_ADDR_FMT:
                  prdata[7:0] <= {fmt_hi_r, pol_r, edge_r, msb_r, select_pin_enable_r,
                                  write_collision_flag_r, trf_r};
               `SMSPI_ADDR_DATA:
                  prdata[7:0] <= sh_data;
               default:
                  prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// *** tb/smspi_slave_model.sv ***
// Behavioural external SPI slave that answers the core's master transfers.
`timescale 1ns/1ps
module smspi_slave_model (
   input wire logic sck,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic msb,
   input wire logic [7:0] reply,
   output logic miso,
   output logic [7:0] got
);
   int n = 0;
   initial miso = 1'b0;
   // Only the master opens a frame; this side never drives the clock.
   always @(negedge sel_n) n = 0;
   // A released line flips so a stale bit can never pass for real data.
   always @(posedge sel_n) miso = ~miso;
   always @(negedge sck) if (!sel_n) miso = reply[msb ? 7 - n : n];
   always @(posedge sck) if (!sel_n) begin
      got = msb ? {got[6:0], mosi} : {mosi, got[7:1]};
      n = n + 1;
   end
endmodule

// *** tb/smspi_core_assertions.sv ***
// Checker for the APB handshake and select pins of the SPI core.
`timescale 1ns/1ps
`include "smspi_consts.vh"
module smspi_core_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire sck_out,
   input wire sck_oe,
   input wire slave_select_n,
   input wire ss_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire mapped = paddr == `SMSPI_ADDR_MODE || paddr == `SMSPI_ADDR_FMT ||
      paddr == `SMSPI_ADDR_DATA;
   wire rd_end = pready && !pwrite;
   ready_wait_a: assert property (
      psel && penable && !pready |=> pready)
      else $error("access phase not answered after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   err_unmapped_a: assert property (
      pready && !mapped |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   err_mapped_a: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   bit4_zero_a: assert property (
      rd_end && paddr == `SMSPI_ADDR_MODE |-> !prdata[4])
      else $error("unused mode bit read as one");
   read_width_a: assert property (
      rd_end |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   ss_master_a: assert property (ss_oe |-> sck_oe)
      else $error("select driven outside master mode");
   sck_framed_a: assert property (
      ss_oe && $changed(sck_out) |-> !slave_select_n || !$past(slave_select_n))
      else $error("serial clock moved outside a selected frame");
   sel_hold_a: assert property (
      $fell(slave_select_n) && ss_oe |=> !slave_select_n [*8])
      else $error("select released too early");
   cover property (pready && pslverr);
   cover property ($fell(slave_select_n) && ss_oe);
   cover property ($rose(sck_oe));
endmodule

// *** tb/tb_top.sv ***
// Top-level bench for the serial module SPI core with its slave partner.
`timescale 1ns/1ps
`include "smspi_consts.vh"
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic pready, pslverr, e, sub_tick = 0, tmr_tick = 0, sck_in = 1;
   logic ss_in_n = 1, sdi, sck_out, sck_oe, sdo, sdo_oe;
   logic slave_select_n, ss_oe, msb = 0, sck_q = 1;
   logic [7:0] reply = 0, got;
   int err_total = 0, samples_checked = 0;
   int cyc = 0, last = 0, hp = 0, nedge = 0;
   smspi_core uut (.*);
   // The select line has a pull-up, so it reads high while floating.
   smspi_slave_model peer (.sck(sck_out), .sel_n(ss_oe ? slave_select_n : 1'b1),
      .mosi(sdo), .msb(msb), .reply(reply), .miso(sdi), .got(got));
   initial forever #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      sub_tick <= (cyc % 6 == 0);
      tmr_tick <= (cyc % 10 == 0);
      sck_q <= sck_out;
      if (sck_out !== sck_q) begin
         hp <= cyc - last;
         last <= cyc;
         nedge <= nedge + 1;
      end
   end
   task automatic chk(input logic [31:0] s, x);
      samples_checked++;
      if (s !== x) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, x);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(0, a, 0);
      chk(q, x);
   endtask
   task automatic wait_trf;
      for (int k = 0; k < 300; k++) begin
         apb(0, `SMSPI_ADDR_FMT, 0);
         if (q[0] === 1'b1) break;
      end
   endtask
   task automatic t_regs;
      rd(`SMSPI_ADDR_MODE, 32'h0000_00E0);
      rd(`SMSPI_ADDR_FMT, 32'h0000_0000);
      apb(1, `SMSPI_ADDR_MODE, 32'h0000_00FC);
      rd(`SMSPI_ADDR_MODE, 32'h0000_00EC);
      rd(12'h00C, 32'h0000_0000);
      chk(e, 1'b1);
      $display("test regs done");
   endtask
   task automatic t_master;
      int half[5] = '{2, 8, 32, 6, 10};
      int n0;
      for (int i = 0; i < 5; i++) begin
         msb <= i[0];
         reply <= 8'h3C + i[7:0];
         apb(1, `SMSPI_ADDR_FMT, {28'h0, i[0], 3'b100});
         apb(1, `SMSPI_ADDR_MODE, {24'h0, i[2:0], 5'h02});
         n0 = nedge;
         apb(1, `SMSPI_ADDR_DATA, 32'h0000_00A5 ^ i);
         apb(1, `SMSPI_ADDR_DATA, 32'h0000_00FF);
         wait_trf;
         chk(nedge - n0, 16);
         chk(hp, half[i]);
         rd(`SMSPI_ADDR_FMT, {28'h0, i[0], 3'b111});
         rd(`SMSPI_ADDR_DATA, 8'h3C + i[7:0]);
         chk(got, 8'hA5 ^ i[7:0]);
         apb(1, `SMSPI_ADDR_FMT, {28'h0, i[0], 3'b100});
         rd(`SMSPI_ADDR_FMT, {28'h0, i[0], 3'b100});
      end
      $display("test master done");
   endtask
   task automatic t_off;
      int n0;
      apb(1, `SMSPI_ADDR_MODE, 32'h0000_0000);
      n0 = nedge;
      apb(1, `SMSPI_ADDR_DATA, 32'h0000_005A);
      repeat (40) @(posedge pclk);
      chk(sck_oe, 1'b0);
      chk(nedge - n0, 0);
      chk(sdo_oe, 1'b0);
      rd(`SMSPI_ADDR_FMT, 32'h0000_0004);
      apb(1, `SMSPI_ADDR_MODE, 32'h0000_00C2);
      n0 = nedge;
      apb(1, `SMSPI_ADDR_DATA, 32'h0000_0066);
      repeat (40) @(posedge pclk);
      chk(sck_oe, 1'b0);
      chk(nedge - n0, 0);
      chk(sdo_oe, 1'b0);
      $display("test off done");
   endtask
   task automatic t_slave;
      apb(1, `SMSPI_ADDR_MODE, 32'h0000_00A2);
      ss_in_n <= 0;
      repeat (4) begin
         repeat (4) @(posedge pclk);
         sck_in <= ~sck_in;
      end
      chk(sdo_oe, 1'b1);
      ss_in_n <= 1;
      repeat (8) @(posedge pclk);
      rd(`SMSPI_ADDR_MODE, 32'h0000_00A3);
      rd(`SMSPI_ADDR_FMT, 32'h0000_0005);
      $display("test slave done");
   endtask
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      err_total++;
      test_done;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_regs;
      t_master;
      t_off;
      t_slave;
      test_done;
   end
endmodule
bind smspi_core smspi_core_checker chk_i (.*);
